// file: hdl/sdram_refresh_and_edge_control.sv
// SDRAM output staging, control register, self-refresh and refresh timing
//
// Contract
// - Interface outputs pass a rising-edge stage then a falling-edge stage; with edge select high the pins bypass the falling-edge stage.
// - Outputs stay stable until the next bus clock edge for hold time.
// - Edge select high launches on rising edge, low on falling edge.
// - Edge select fed by buffered clock launches on that clock's rising edge.
// - Control bit 15 selects memory type; zero, asynchronous, at reset.
// - Synchronous mode cannot be left except by device reset.
// - Bit 13 clear multiplexes column addresses; set drives linear addresses.
// - Bit 12 clear: clock-enable pin is true enable, self-refresh by request bit.
// - Bit 12 set: clock-enable pin carries command, no self-refresh performed.
// - Setting bit 11 in enable use issues self-refresh entry to both blocks.
// - Clearing the request bit after entry issues self-refresh exit.
// - Refresh interval counter is suspended during self-refresh.
// - Bits 10:9 give refresh-to-activate gap: 3, 6 or 9 clocks.
// - Same refresh-to-activate gap applies to both memory blocks.
// - Refresh spacing is (count + 1) times 16 bus clocks.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "sdram_refresh_consts.svh"

module sdram_refresh_and_edge_control
    import sdram_refresh_pkg::*;
#(
    parameter int ADDR_W = `ADDR_W,
    parameter int DATA_W = `DATA_W
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              outputEdgeSelect,
    input  wire logic [ADDR_W-1:0] rowAddr,
    input  wire logic [ADDR_W-1:0] colAddr,
    input  wire logic [ADDR_W-1:0] linearAddr,
    input  wire logic              columnPhase,
    input  wire logic [DATA_W-1:0] writeData,
    input  wire sdram_ctrl_s       userCtrl,
    input  wire logic              commandBit,
    output sdram_pins_s            sdramPins,
    output logic                   refreshDue,
    output logic                   rowActivateOk,
    output logic                   inSelfRefresh
);

    // Widths are fixed by the packed pin struct; other values cannot be served
    if (ADDR_W != `ADDR_W) begin : g_bad_addr_w
        $error("ADDR_W must match the packed pin struct");
    end
    if (DATA_W != `DATA_W) begin : g_bad_data_w
        $error("DATA_W must match the packed pin struct");
    end
    // The prescaler is five bits wide
    if (`REFRESH_PRESCALE < 2 || `REFRESH_PRESCALE > 32) begin : g_bad_prescale
        $error("Refresh prescale does not fit its counter");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register bus

    ctrl_fields_s ctrl;
    self_state_e  selfState;
    logic [15:0]  ctrlWord;
    logic         setupPhase;
    logic         accessPhase;
    logic         hitCtrl;
    logic         hitStatus;
    logic [15:0]  wrValue;
    logic         ctrlWrite;
    logic [31:0]  statusWord;

    // Reset word split into fields; the reserved bit has no storage
    localparam logic [15:0] CTRL_RESET_WORD = `CTRL_RESET;

    assign ctrlWord    = {ctrl.syncMode, 1'b0, ctrl.noAddrMux, ctrl.ckeAsCommand,
                          ctrl.selfRefreshRequest, ctrl.refreshRecoveryTime,
                          ctrl.refreshIntervalCount};
    assign setupPhase  = psel && !penable;
    assign accessPhase = psel && penable;
    // Full 12-bit decode, so aliases of the two registers answer with an error
    assign hitCtrl     = (paddr == `CTRL_OFFSET);
    assign hitStatus   = (paddr == `STATUS_OFFSET);
    // Upper half of the bus word is ignored and the reserved bit never stored
    assign wrValue     = pwdata[15:0] & `CTRL_WRITE_MASK;
    assign ctrlWrite   = accessPhase && pwrite && hitCtrl;
    assign statusWord  = {28'h0000000, rowActivateOk, refreshDue, selfState};

    // Zero-wait slave: answer is ready in every access phase
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready <= 1'b1;
        end else begin
            pready <= 1'b1;
        end
    end

    // Read data and error prepared in the setup phase, valid in the access phase
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            pslverr <= !(hitCtrl || hitStatus);
            if (!pwrite && hitCtrl) begin
                prdata <= {16'h0000, ctrlWord};
            end else if (!pwrite && hitStatus) begin
                prdata <= statusWord;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= '{syncMode:             CTRL_RESET_WORD[`BIT_SYNC_MODE],
                      noAddrMux:            CTRL_RESET_WORD[`BIT_NO_ADDR_MUX],
                      ckeAsCommand:         CTRL_RESET_WORD[`BIT_CKE_AS_CMD],
                      selfRefreshRequest:   CTRL_RESET_WORD[`BIT_SELF_REQ],
                      refreshRecoveryTime:  CTRL_RESET_WORD[`FIELD_REFRESH_RECOVERY_TIME_HI:`FIELD_REFRESH_RECOVERY_TIME_LO],
                      refreshIntervalCount: CTRL_RESET_WORD[`FIELD_RC_HI:`FIELD_RC_LO]};
        end else if (ctrlWrite) begin
            ctrl.syncMode             <= ctrl.syncMode | wrValue[`BIT_SYNC_MODE];
            ctrl.noAddrMux            <= wrValue[`BIT_NO_ADDR_MUX];
            ctrl.ckeAsCommand         <= wrValue[`BIT_CKE_AS_CMD];
            ctrl.selfRefreshRequest   <= wrValue[`BIT_SELF_REQ];
            ctrl.refreshRecoveryTime  <= wrValue[`FIELD_REFRESH_RECOVERY_TIME_HI:`FIELD_REFRESH_RECOVERY_TIME_LO];
            ctrl.refreshIntervalCount <= wrValue[`FIELD_RC_HI:`FIELD_RC_LO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Self-refresh sequencing

    self_state_e next_selfState;
    logic        selfAllowed;

    // Only a true clock enable can drive self-refresh
    assign selfAllowed = !ctrl.ckeAsCommand;

    always_comb begin
        next_selfState = selfState;
        unique case (selfState)
            SR_IDLE: begin
                if (ctrl.selfRefreshRequest && selfAllowed) begin
                    next_selfState = SR_ENTER;
                end
            end
            SR_ENTER: begin
                next_selfState = SR_HELD;
            end
            SR_HELD: begin
                if (!ctrl.selfRefreshRequest) begin
                    next_selfState = SR_EXIT;
                end
                // A command-driven pin cannot hold self-refresh
                if (ctrl.ckeAsCommand) begin
                    next_selfState = SR_EXIT;
                end
            end
            SR_EXIT: begin
                next_selfState = SR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            selfState <= SR_IDLE;
        end else begin
            selfState <= next_selfState;
        end
    end

    // Taken from the next state so the flag lines up with the staged pins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            inSelfRefresh <= 1'b0;
        end else begin
            inSelfRefresh <= (next_selfState == SR_ENTER) || (next_selfState == SR_HELD);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Refresh interval and recovery

    logic [4:0] prescale;
    logic [8:0] intervalCount;
    logic [3:0] recovery;
    logic       suspended;
    logic       refreshTick;

    // Counter held while memories refresh themselves
    assign suspended   = (selfState != SR_IDLE);
    assign refreshTick = !suspended && (prescale == 5'(`REFRESH_PRESCALE - 1))
                         && (intervalCount == 9'h000);

    // Suspension keeps the count, but the register write that ends it restarts the interval
    // Sixteen-clock prescale times (count + 1)
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prescale      <= 5'h00;
            intervalCount <= 9'h000;
        end else if (ctrlWrite) begin
            // Restart so a new spacing applies cleanly
            prescale      <= 5'h00;
            intervalCount <= wrValue[`FIELD_RC_HI:`FIELD_RC_LO];
        end else if (!suspended) begin
            if (prescale == 5'(`REFRESH_PRESCALE - 1)) begin
                prescale <= 5'h00;
                if (intervalCount == 9'h000) begin
                    intervalCount <= ctrl.refreshIntervalCount;
                end else begin
                    intervalCount <= intervalCount - 9'h001;
                end
            end else begin
                prescale <= prescale + 5'h01;
            end
        end
    end

    // One-cycle pulse to the access sequencer, which issues the refresh itself
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            refreshDue <= 1'b0;
        end else begin
            refreshDue <= refreshTick;
        end
    end

    // Recovery gap by field; one setting for both blocks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            recovery <= 4'h0;
        end else if (refreshTick) begin
            unique case (ctrl.refreshRecoveryTime)
                2'b00:   recovery <= `RECOVERY_SHORT;
                2'b01:   recovery <= `RECOVERY_MEDIUM;
                default: recovery <= `RECOVERY_LONG;
            endcase
        end else if (recovery != 4'h0) begin
            recovery <= recovery - 4'h1;
        end
    end

    // Ready again when one recovery clock remains, so the gap is the full count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rowActivateOk <= 1'b1;
        end else begin
            rowActivateOk <= !refreshTick && (recovery <= 4'h1) && !suspended;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin value selection

    sdram_pins_s next_pins;

    // Control words for self-refresh entry and for the rest of the sequence
    localparam sdram_ctrl_s SELF_ENTRY_CMD = '{sras_n: 1'b0, scas_n: 1'b0, dramw: 1'b0,
                                               bankSel_n: 2'b00, byteMask: 4'hF};
    localparam sdram_ctrl_s DESELECT_CMD   = '{sras_n: 1'b1, scas_n: 1'b1, dramw: 1'b0,
                                               bankSel_n: 2'b11, byteMask: 4'hF};

    always_comb begin
        next_pins      = '0;
        next_pins.data = writeData;
        next_pins.ctrl = userCtrl;
        if (ctrl.noAddrMux) begin
            next_pins.addr = linearAddr;
        end else begin
            next_pins.addr = columnPhase ? colAddr : rowAddr;
        end
        // Command bit on the enable pin, no self-refresh
        if (ctrl.ckeAsCommand) begin
            next_pins.cke = commandBit;
        end else begin
            next_pins.cke = (next_selfState == SR_IDLE) || (next_selfState == SR_EXIT);
        end
        if (next_selfState == SR_ENTER) begin
            next_pins.ctrl = SELF_ENTRY_CMD;
        end else if (next_selfState != SR_IDLE) begin
            // Exit is a deselect with the enable raised
            next_pins.ctrl = DESELECT_CMD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage output staging

    sdram_pins_s riseStage;
    sdram_pins_s fallStage;
    logic        launchRising;

    // First stage on the rising edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            riseStage <= '0;
        end else begin
            riseStage <= next_pins;
        end
    end

    // Second stage on the falling edge
    always_ff @(negedge mclk or posedge rst) begin
        if (rst) begin
            fallStage <= '0;
        end else begin
            fallStage <= riseStage;
        end
    end

    // A buffered clock is high at the rising sample, so it picks rising launch
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            launchRising <= 1'b1;
        end else begin
            launchRising <= outputEdgeSelect;
        end
    end

    // Launch edge choice; each stage holds until its next edge
    assign sdramPins = launchRising ? riseStage : fallStage;

endmodule

// file: hdl/sdram_refresh_consts.svh
// Offsets, field positions, reset values and timing counts of the SDRAM refresh block
`ifndef SDRAM_REFRESH_CONSTS_SVH
`define SDRAM_REFRESH_CONSTS_SVH

`define CTRL_OFFSET        12'h000
`define STATUS_OFFSET      12'h004
`define CTRL_RESET         16'h0000
`define CTRL_WRITE_MASK    16'hBFFF
`define BIT_SYNC_MODE      15
`define BIT_RESERVED       14
`define BIT_NO_ADDR_MUX    13
`define BIT_CKE_AS_CMD     12
`define BIT_SELF_REQ       11
`define FIELD_REFRESH_RECOVERY_TIME_HI      10
`define FIELD_REFRESH_RECOVERY_TIME_LO      9
`define FIELD_RC_HI        8
`define FIELD_RC_LO        0
`define RECOVERY_SHORT     4'h3
`define RECOVERY_MEDIUM    4'h6
`define RECOVERY_LONG      4'h9
`define REFRESH_PRESCALE   5'h10
`define ADDR_W             13
`define DATA_W             32

`endif

// file: hdl/sdram_refresh_pkg.sv
// Types shared by the SDRAM refresh and edge control block
package sdram_refresh_pkg;
    `include "sdram_refresh_consts.svh"

    typedef struct packed {
        logic              sras_n;
        logic              scas_n;
        logic              dramw;
        logic [1:0]        bankSel_n;
        logic [3:0]        byteMask;
    } sdram_ctrl_s;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] data;
        sdram_ctrl_s        ctrl;
        logic               cke;
    } sdram_pins_s;

    typedef struct packed {
        logic       syncMode;
        logic       noAddrMux;
        logic       ckeAsCommand;
        logic       selfRefreshRequest;
        logic [1:0] refreshRecoveryTime;
        logic [8:0] refreshIntervalCount;
    } ctrl_fields_s;

    typedef enum logic [1:0] {
        SR_IDLE  = 2'b00,
        SR_ENTER = 2'b01,
        SR_HELD  = 2'b10,
        SR_EXIT  = 2'b11
    } self_state_e;
endpackage

// file: tb/sdram_model.sv
// Behavioural SDRAM pair with optional external command routing
`timescale 1ns/1ps
module sdram_model
    import sdram_refresh_pkg::*;
#(
    parameter int AW = 13
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire sdram_pins_s pins,
    input  wire logic        routeCmd,
    output logic             selfActive,
    output logic [AW-1:0]    muxedAddr
);
    logic lastCke;
    assign muxedAddr = routeCmd ? {pins.addr[AW-1:11], pins.cke, pins.addr[9:0]} : pins.addr;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            selfActive <= 1'b0;
            lastCke    <= 1'b0;
        end else begin
            lastCke <= pins.cke;
            if (lastCke && !pins.cke && !pins.ctrl.sras_n && !pins.ctrl.scas_n
                && pins.ctrl.bankSel_n == 2'b00)
                selfActive <= 1'b1;
            else if (pins.cke)
                selfActive <= 1'b0;
        end
    end
endmodule

// file: tb/sdram_refresh_chk.sv
// Port-level assertions for the SDRAM refresh and edge control block
`timescale 1ns/1ps
module sdram_refresh_chk
    import sdram_refresh_pkg::*;
#(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 32
) (
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire logic [DATA_W-1:0] writeData,
    input wire sdram_pins_s       sdramPins,
    input wire logic              refreshDue,
    input wire logic              rowActivateOk,
    input wire logic              inSelfRefresh
);
    logic syncSeen;
    wire  ctrlRd = psel && penable && !pwrite && paddr == 12'h000;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Only a reset may clear the mode bit, so a write of one is remembered
    always_ff @(posedge mclk or posedge rst) begin
        if (rst)
            syncSeen <= 1'b0;
        else if (psel && penable && pwrite && paddr == 12'h000 && pwdata[15])
            syncSeen <= 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_slverr; psel && penable |-> pslverr == (paddr != 12'h000 && paddr != 12'h004);
    endproperty
    a_slverr: assert property (p_slverr) else $error("pslverr wrong");
    property p_sync; ctrlRd |-> prdata[15] == syncSeen;
    endproperty
    a_sync: assert property (p_sync) else $error("mode bit wrong");
    property p_rsvd; ctrlRd |-> prdata[31:16] == 16'h0000 && !prdata[14];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_pulse; refreshDue |=> !refreshDue [*8];
    endproperty
    a_pulse: assert property (p_pulse) else $error("refresh too close");
    property p_suspend; inSelfRefresh |-> !refreshDue;
    endproperty
    a_suspend: assert property (p_suspend) else $error("refresh in self");
    property p_recov; refreshDue && !inSelfRefresh |-> ##[0:1] !rowActivateOk ##[1:10] rowActivateOk;
    endproperty
    a_recov: assert property (p_recov) else $error("recovery wrong");
    property p_cke_self; inSelfRefresh [*4] |-> !sdramPins.cke;
    endproperty
    a_cke_self: assert property (p_cke_self) else $error("cke high in self");
    property p_stage; !$past(rst) && !inSelfRefresh |-> sdramPins.data == $past(writeData);
    endproperty
    a_stage: assert property (p_stage) else $error("data stage wrong");
endmodule

bind sdram_refresh_and_edge_control sdram_refresh_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_i (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr,
    .writeData, .sdramPins, .refreshDue, .rowActivateOk, .inSelfRefresh);

// file: tb/tb.sv
// Self-checking bench for the SDRAM refresh and edge control block
`timescale 1ns/1ps
module tb;
    import sdram_refresh_pkg::*;
    logic        mclk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        outputEdgeSelect, columnPhase, commandBit, routeCmd;
    logic        refreshDue, rowActivateOk, inSelfRefresh, selfActive;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, writeData;
    logic [12:0] rowAddr, colAddr, linearAddr, muxedAddr;
    sdram_ctrl_s userCtrl;
    sdram_pins_s sdramPins;
    int          mismatches, n_checks, n, lo;
    sdram_refresh_and_edge_control dut (
        .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .outputEdgeSelect, .rowAddr, .colAddr, .linearAddr, .columnPhase, .writeData,
        .userCtrl, .commandBit, .sdramPins, .refreshDue, .rowActivateOk, .inSelfRefresh);
    sdram_model model (.mclk, .rst, .pins(sdramPins), .routeCmd, .selfActive, .muxedAddr);
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'hFFFF3FFF);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h00003FFF);
        chk(32'(inSelfRefresh), 32'h0);
        apb(1'b1, 12'h000, 32'h8000);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h8000);
        apb(1'b1, 12'h008, 32'h1);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
    endtask
    // Falling launch keeps the old value past the rising edge
    task automatic edge_case(input logic sel);
        @(posedge mclk);
        outputEdgeSelect <= sel;
        writeData        <= 32'h11111111;
        repeat (3) @(posedge mclk);
        writeData <= 32'h22222222;
        @(posedge mclk);
        #5 chk(sdramPins.data, sel ? 32'h22222222 : 32'h11111111);
        @(negedge mclk);
        #5 chk(sdramPins.data, 32'h22222222);
    endtask
    task automatic t_pins();
        apb(1'b1, 12'h000, 32'h8000);
        repeat (3) @(posedge mclk);
        chk(32'(sdramPins.addr), 32'h0AAA);
        chk(32'(sdramPins.ctrl), 32'h1A5);
        chk(32'(sdramPins.cke), 32'h1);
        columnPhase <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(32'(sdramPins.addr), 32'h1555);
        apb(1'b1, 12'h000, 32'hB000);
        routeCmd <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(32'(sdramPins.addr), 32'h0F0F);
        chk(32'(sdramPins.cke), 32'h0);
        chk(32'(muxedAddr), 32'h0B0F);
        commandBit <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(32'(sdramPins.cke), 32'h1);
        chk(32'(muxedAddr), 32'h0F0F);
        for (int s = 0; s < 2; s++)
            edge_case(s[0]);
        @(posedge mclk);
        outputEdgeSelect <= 1'b1;
    endtask
    task automatic t_refresh();
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, 12'h000, 32'h8003 | (r << 9));
            n = 0;
            while (refreshDue !== 1'b1 && n < 200) begin
                @(posedge mclk);
                n++;
            end
            chk(32'(refreshDue), 32'h1);
            n = 0;
            lo = 0;
            do begin
                @(posedge mclk);
                n++;
                lo += (rowActivateOk === 1'b0);
            end while (refreshDue !== 1'b1 && n < 200);
            chk(n, 64);
            chk(lo, r == 0 ? 3 : r == 1 ? 6 : 9);
        end
    endtask
    // Short fixed waits: entry and exit each take one state cycle plus staging
    task automatic t_self();
        apb(1'b1, 12'h000, 32'h8803);
        repeat (8) @(posedge mclk);
        chk(32'(inSelfRefresh), 32'h1);
        chk(32'(selfActive), 32'h1);
        chk(32'(sdramPins.cke), 32'h0);
        n = 0;
        repeat (200) begin
            @(posedge mclk);
            n += (refreshDue === 1'b1);
        end
        chk(n, 0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, 12'h000, 32'h8003);
        repeat (8) @(posedge mclk);
        chk(32'(inSelfRefresh), 32'h0);
        chk(32'(selfActive), 32'h0);
        chk(32'(sdramPins.cke), 32'h1);
    endtask
    // A second reset in mid-run is the only way back to asynchronous mode
    task automatic t_reset();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(32'(sdramPins.cke), 32'h0);
        chk(32'(inSelfRefresh), 32'h0);
        rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Whole run needs under two thousand cycles; ten times that means a hang
    initial begin
        #(25 * 20000);
        mismatches++;
        finish_test();
    end
    initial begin
        {psel, penable, pwrite, columnPhase, commandBit, routeCmd} = '0;
        {paddr, pwdata} = '0;
        rst = 1'b1;
        outputEdgeSelect = 1'b1;
        rowAddr = 13'h0AAA;
        colAddr = 13'h1555;
        linearAddr = 13'h0F0F;
        writeData = 32'h0;
        userCtrl = sdram_ctrl_s'(9'h1A5);
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_pins();
        t_refresh();
        t_self();
        t_reset();
        finish_test();
    end
endmodule
